// >>> dps_host.sv
// Serial host model driving frames on the potentiometer link
`timescale 1ns/100ps
module dps_host (
  // Serial link
  output logic       sck,
  output logic       cs_n,
  output logic       hold_n,
  output logic       si,
  input  wire logic  so_o,
  input  wire logic  so_oe_n
);
  localparam realtime HALF = 62.5;
  wire so_w = so_oe_n ? 1'bz : so_o;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    si = 1'b0;
  end
  // Bits MSB first, optional pause before one bit
  task automatic frame(input logic [23:0] bits, input int n, input int pause_at,
                       output logic [7:0] rd);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i == pause_at) begin
        #HALF hold_n = 1'b0;
        si = ~bits[23-i];
        #HALF sck = 1'b1;
        #HALF sck = 1'b0;
        #HALF hold_n = 1'b1;
        #HALF;
      end
      si = bits[23-i];
      #HALF sck = 1'b1;
      rd = {rd[6:0], so_w};
      #HALF sck = 1'b0;
    end
    #HALF cs_n = 1'b1;
    si = ~si;
  endtask
endmodule // dps_host

// >>> dps_pkg.sv
// Shared constants, types and helpers for the dual potentiometer serial control
package dps_pkg;

  // Array organisation
  localparam int POT_N  = 2;
  localparam int DR_N   = 4;
  localparam int DATA_W = 8;
  localparam int TAP_N  = 256;
  localparam int SEG_N  = 255;

  // Identification byte layout; the type code is arbitrary
  localparam logic [3:0] DEV_TYPE    = 4'hA;
  localparam int         ID_TYPE_HI  = 7;
  localparam int         ID_TYPE_LO  = 4;
  localparam int         ID_ADDR_HI  = 1;
  localparam int         ID_ADDR_LO  = 0;

  // Instruction byte layout
  localparam int INS_OP_HI   = 7;
  localparam int INS_OP_LO   = 6;
  localparam int INS_WIPER_BIT = 5;
  localparam int INS_IDX_HI  = 3;
  localparam int INS_IDX_LO  = 2;
  localparam int INS_POT_BIT = 0;

  // Reset contents of the stored and wiper registers, and the last bit index of a byte
  localparam logic [7:0] DR_RESET     = 8'h80;
  localparam logic [7:0] WIPER_RESET  = 8'h00;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  // Nonvolatile write time
  localparam int CLK_HZ       = 25_000_000;
  localparam int NV_WRITE_MS  = 10;
  localparam int NV_WRITE_CYC = (CLK_HZ / 1000) * NV_WRITE_MS;
  localparam int NV_CNT_W     = 18;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_XFER  = 2'h2,
    OP_STORE = 2'h3
  } dps_op_t;

  typedef enum logic [1:0] {
    ST_ID   = 2'b00,
    ST_INS  = 2'b01,
    ST_DATA = 2'b11,
    ST_IDLE = 2'b10
  } dps_frame_t;

  function automatic logic [TAP_N-1:0] dps_tap_onehot(input logic [DATA_W-1:0] pos);
    dps_tap_onehot = {{(TAP_N-1){1'b0}}, 1'b1} << pos;
  endfunction

endpackage

// >>> dps_pot.sv
// One potentiometer: wiper position, four stored registers, tap decoder
`timescale 1ns/100ps
module dps_pot (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Bank control
  dps_pot_if.pot    pif
);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pif.wiper <= dps_pkg::WIPER_RESET;
    end else if (pif.recall) begin
      pif.wiper <= pif.dr[0];
    end else if (pif.wr_wiper) begin
      pif.wiper <= pif.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < dps_pkg::DR_N; i++) begin
        pif.dr[i] <= dps_pkg::DR_RESET;
      end
    end else if (pif.wr_dr) begin
      pif.dr[pif.idx] <= pif.wdata;
    end
  end

  // One closed switch among the taps of the segment string
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pif.taps <= dps_pkg::dps_tap_onehot(dps_pkg::WIPER_RESET);
    end else begin
      pif.taps <= dps_pkg::dps_tap_onehot(pif.wiper);
    end
  end

endmodule // dps_pot

// >>> dps_pot_if.sv
// Control and contents of one potentiometer register bank
`timescale 1ns/100ps
interface dps_pot_if;
  logic                               recall;
  logic                               wr_wiper;
  logic                               wr_dr;
  logic [1:0]                         idx;
  logic [dps_pkg::DATA_W-1:0]         wdata;
  logic [dps_pkg::DATA_W-1:0]         wiper;
  logic [dps_pkg::DATA_W-1:0]         dr [dps_pkg::DR_N];
  logic [dps_pkg::TAP_N-1:0]          taps;

  modport ctl (output recall, wr_wiper, wr_dr, idx, wdata, input wiper, dr, taps);
  modport pot (input recall, wr_wiper, wr_dr, idx, wdata, output wiper, dr, taps);
endinterface

// >>> dps_props.sv
// Concurrent checks on the dual potentiometer serial control ports
`timescale 1ns/100ps
module dps_props #(
  parameter int NV_WRITE_CYC = 20
) (
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       nrst,
  // Serial link and protection
  input wire logic                       sck,
  input wire logic                       cs_n,
  input wire logic                       hold_n,
  input wire logic                       so_o,
  input wire logic                       so_oe_n,
  input wire logic                       wp_n,
  // Taps and status
  input wire logic [dps_pkg::TAP_N-1:0]  tap_sel0,
  input wire logic [dps_pkg::TAP_N-1:0]  tap_sel1,
  input wire logic                       nv_busy
);
  int busy_cnt;
  int rst_age;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      busy_cnt <= 0;
    else
      busy_cnt <= nv_busy ? busy_cnt + 1 : 0;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      rst_age <= 0;
    else if (rst_age < 7)
      rst_age <= rst_age + 1;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_sck_high;
    sck && $past(sck);
  endsequence
  desel_float_a: assert property (cs_n |-> so_oe_n)
    else $error("output driven while deselected");
  hold_float_a: assert property (!hold_n |-> so_oe_n)
    else $error("output driven during pause");
  so_steady_a: assert property (s_sck_high |-> $stable(so_o))
    else $error("output changed while serial clock high");
  tap_onehot_a: assert property ($onehot(tap_sel0) && $onehot(tap_sel1))
    else $error("tap select not one-hot");
  power_recall_a: assert property (rst_age == 3 |->
      tap_sel0[dps_pkg::DR_RESET] && tap_sel1[dps_pkg::DR_RESET])
    else $error("wiper not recalled after reset");
  busy_bound_a: assert property (busy_cnt <= NV_WRITE_CYC)
    else $error("write time too long");
  busy_length_a: assert property ($fell(nv_busy) |-> busy_cnt == NV_WRITE_CYC - 1)
    else $error("write time length wrong");
  protect_busy_a: assert property ($rose(nv_busy) |-> $past(wp_n, 3))
    else $error("stored write while protected");
  busy_taps_a: assert property (($changed(tap_sel0) || $changed(tap_sel1))
      |-> !$past(nv_busy, 2))
    else $error("wiper changed by command during write time");
endmodule // dps_props

bind dps_top dps_props #(.NV_WRITE_CYC(NV_WRITE_CYC)) props_u (.clk_sys(clk_sys), .nrst(nrst),
  .sck(sck), .cs_n(cs_n), .hold_n(hold_n), .so_o(so_o), .so_oe_n(so_oe_n), .wp_n(wp_n),
  .tap_sel0(tap_sel0), .tap_sel1(tap_sel1), .nv_busy(nv_busy));

// >>> dps_top.sv
// Serial slave and register control for two digitally set potentiometers
//
// What this block does
// - Each pot keeps a wiper register and four stored registers, all host accessible.
// - Wiper value closes exactly one of 256 taps over 255 segments.
// - After reset each wiper is loaded from its stored register zero.
// - Read data changes on the serial output at falling serial clock edges.
// - Host sends everything on serial input; device samples on rising edges.
// - Hold input floats the output and pauses a transfer.
// - Hold changes only while clock low; sequence resumes without reset.
// - Chip select high floats output, ignores bus; first frame needs a falling select.
// - Write protect low blocks every stored register write.
// - A stored register change completes within 10 ms of write time.
`timescale 1ns/100ps
module dps_top #(
  parameter int NV_WRITE_CYC = dps_pkg::NV_WRITE_CYC
) (
  // System clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  // Serial link
  input  wire logic                        sck,
  input  wire logic                        cs_n,
  input  wire logic                        hold_n,
  input  wire logic                        si,
  output logic                             so_o,
  output logic                             so_oe_n,
  // Straps and protection
  input  wire logic                        slave_addr_bit0,
  input  wire logic                        slave_addr_bit1,
  input  wire logic                        wp_n,
  // Potentiometer taps and status
  output logic [dps_pkg::TAP_N-1:0]        tap_sel0,
  output logic [dps_pkg::TAP_N-1:0]        tap_sel1,
  output logic                             nv_busy
);

  localparam logic [dps_pkg::NV_CNT_W-1:0] NV_LOAD = dps_pkg::NV_CNT_W'(NV_WRITE_CYC - 1);

  dps_pot_if pif [dps_pkg::POT_N] ();

  // Link domain state
  logic                                    frame_clr;
  logic                                    armed;
  logic [1:0]                              addr_s1;
  logic [1:0]                              addr_s2;
  logic [2:0]                              bit_cnt;
  logic [6:0]                              shreg;
  logic [7:0]                              byte_in;
  dps_pkg::dps_frame_t                     state;
  dps_pkg::dps_op_t                        cmd_op;
  logic                                    cmd_to_wiper;
  logic [1:0]                              cmd_idx;
  logic                                    cmd_pot;
  logic [7:0]                              cmd_data;
  logic                                    cmd_tog;
  logic [7:0]                              so_sh;
  logic                                    so_drv;
  logic [7:0]                              rd_word;
  // System domain state
  logic                                    tog_s1;
  logic                                    tog_s2;
  logic                                    tog_s3;
  logic                                    cmd_evt;
  logic                                    wp_s1;
  logic                                    wp_s2;
  logic                                    recall_done;
  logic [dps_pkg::NV_CNT_W-1:0]            nv_cnt;
  logic [dps_pkg::POT_N-1:0]               dr_wr;
  logic [7:0]                              wiper_q [dps_pkg::POT_N];
  logic [7:0]                              dr_q [dps_pkg::POT_N][dps_pkg::DR_N];

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: selection and input shifting

  assign frame_clr = cs_n | ~nrst;
  assign byte_in   = {shreg, si};

  // A falling select after reset arms the frame logic
  always_ff @(negedge cs_n or negedge nrst) begin
    if (!nrst) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      addr_s1 <= 2'h0;
      addr_s2 <= 2'h0;
    end else begin
      addr_s1 <= {slave_addr_bit1, slave_addr_bit0};
      addr_s2 <= addr_s1;
    end
  end

  // Hold low freezes the frame in place
  always_ff @(posedge sck or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt <= 3'h0;
      shreg   <= 7'h00;
    end else if (hold_n && armed) begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg   <= byte_in[6:0];
    end
  end

  always_ff @(posedge sck or posedge frame_clr) begin
    if (frame_clr) begin
      state <= dps_pkg::ST_ID;
    end else if (hold_n && armed && bit_cnt == dps_pkg::BIT_LAST) begin
      unique case (state)
        dps_pkg::ST_ID: begin
          if (byte_in[dps_pkg::ID_TYPE_HI:dps_pkg::ID_TYPE_LO] == dps_pkg::DEV_TYPE &&
              byte_in[dps_pkg::ID_ADDR_HI:dps_pkg::ID_ADDR_LO] == addr_s2) begin
            state <= dps_pkg::ST_INS;
          end else begin
            state <= dps_pkg::ST_IDLE;
          end
        end
        dps_pkg::ST_INS: begin
          if (byte_in[dps_pkg::INS_OP_HI:dps_pkg::INS_OP_LO] == dps_pkg::OP_XFER ||
              byte_in[dps_pkg::INS_OP_HI:dps_pkg::INS_OP_LO] == dps_pkg::OP_STORE) begin
            state <= dps_pkg::ST_IDLE;
          end else begin
            state <= dps_pkg::ST_DATA;
          end
        end
        dps_pkg::ST_DATA: state <= dps_pkg::ST_IDLE;
        dps_pkg::ST_IDLE: state <= dps_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: command capture, held across the frame end for the crossing

  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      cmd_op   <= dps_pkg::OP_READ;
      cmd_to_wiper <= 1'b0;
      cmd_idx  <= 2'h0;
      cmd_pot  <= 1'b0;
      cmd_data <= 8'h00;
      cmd_tog  <= 1'b0;
    end else if (!cs_n && hold_n && armed && bit_cnt == dps_pkg::BIT_LAST) begin
      if (state == dps_pkg::ST_INS) begin
        cmd_op  <= dps_pkg::dps_op_t'(byte_in[dps_pkg::INS_OP_HI:dps_pkg::INS_OP_LO]);
        cmd_to_wiper <= byte_in[dps_pkg::INS_WIPER_BIT];
        cmd_idx <= byte_in[dps_pkg::INS_IDX_HI:dps_pkg::INS_IDX_LO];
        cmd_pot <= byte_in[dps_pkg::INS_POT_BIT];
        if (byte_in[dps_pkg::INS_OP_HI:dps_pkg::INS_OP_LO] == dps_pkg::OP_XFER ||
            byte_in[dps_pkg::INS_OP_HI:dps_pkg::INS_OP_LO] == dps_pkg::OP_STORE) begin
          cmd_tog <= ~cmd_tog;
        end
      end else if (state == dps_pkg::ST_DATA && cmd_op == dps_pkg::OP_WRITE) begin
        cmd_data <= byte_in;
        cmd_tog  <= ~cmd_tog;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: read data out on falling edges

  // Register contents only change on commands, so they are stable while read
  assign rd_word = cmd_to_wiper ? wiper_q[cmd_pot] : dr_q[cmd_pot][cmd_idx];

  always_ff @(negedge sck or posedge frame_clr) begin
    if (frame_clr) begin
      so_sh  <= 8'h00;
      so_drv <= 1'b0;
    end else if (hold_n) begin
      if (state == dps_pkg::ST_DATA && cmd_op == dps_pkg::OP_READ) begin
        so_drv <= 1'b1;
        if (bit_cnt == 3'h0) begin
          so_sh <= rd_word;
        end else begin
          so_sh <= {so_sh[6:0], 1'b0};
        end
      end else begin
        so_drv <= 1'b0;
      end
    end
  end

  assign so_o    = so_sh[7];
  assign so_oe_n = ~(so_drv & hold_n & ~cs_n);

  ////////////////////////////////////////////////////////////////////////////
  // System domain: crossing, protection, write timer

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      wp_s1  <= 1'b0;
      wp_s2  <= 1'b0;
    end else begin
      tog_s1 <= cmd_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      wp_s1  <= wp_n;
      wp_s2  <= wp_s1;
    end
  end

  assign cmd_evt = tog_s2 ^ tog_s3;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      recall_done <= 1'b0;
    end else begin
      recall_done <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      nv_cnt <= '0;
    end else if (|dr_wr) begin
      nv_cnt <= NV_LOAD;
    end else if (nv_cnt != '0) begin
      nv_cnt <= nv_cnt - 1'b1;
    end
  end

  assign nv_busy = (nv_cnt != '0);

  ////////////////////////////////////////////////////////////////////////////
  // Potentiometer banks

  for (genvar g = 0; g < dps_pkg::POT_N; g++) begin : g_pot
    logic hit;

    assign hit = cmd_evt & ~nv_busy & (cmd_pot == 1'(g));
    assign pif[g].recall   = ~recall_done;
    assign pif[g].idx      = cmd_idx;
    assign pif[g].wr_wiper = hit & ((cmd_op == dps_pkg::OP_WRITE & cmd_to_wiper) |
                                    cmd_op == dps_pkg::OP_XFER);
    assign dr_wr[g]        = hit & wp_s2 & ((cmd_op == dps_pkg::OP_WRITE & ~cmd_to_wiper) |
                                            cmd_op == dps_pkg::OP_STORE);
    assign pif[g].wr_dr    = dr_wr[g];
    assign pif[g].wdata    = (cmd_op == dps_pkg::OP_XFER)  ? pif[g].dr[cmd_idx] :
                             (cmd_op == dps_pkg::OP_STORE) ? pif[g].wiper : cmd_data;
    assign wiper_q[g]      = pif[g].wiper;
    for (genvar r = 0; r < dps_pkg::DR_N; r++) begin : g_dr
      assign dr_q[g][r] = pif[g].dr[r];
    end

    dps_pot u_pot (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .pif     (pif[g])
    );
  end

  assign tap_sel0 = pif[0].taps;
  assign tap_sel1 = pif[1].taps;

endmodule // dps_top

// >>> dual_pot_serial_control_test.sv
// Self-checking bench for the dual potentiometer serial control
`timescale 1ns/100ps
module dual_pot_serial_control_test;
  localparam int NV_CYC = 200;
  logic                       clk_sys = 1'b0;
  logic                       nrst = 1'b0;
  logic                       sck, cs_n, hold_n, si, so_o, so_oe_n, nv_busy;
  logic                       slave_addr_bit0 = 1'b0;
  logic                       slave_addr_bit1 = 1'b0;
  logic                       wp_n = 1'b1;
  logic [dps_pkg::TAP_N-1:0]  tap_sel0, tap_sel1;
  logic [7:0]                 exp_wiper [2];
  logic [7:0]                 exp_store [2][4];
  logic [7:0]                 id_b, rd, v;
  int                         num_errors = 0;
  int                         tests_run = 0;

  always #20 clk_sys = ~clk_sys;

  dps_top #(.NV_WRITE_CYC(NV_CYC)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .sck(sck),
    .cs_n(cs_n), .hold_n(hold_n), .si(si), .so_o(so_o), .so_oe_n(so_oe_n),
    .slave_addr_bit0(slave_addr_bit0), .slave_addr_bit1(slave_addr_bit1), .wp_n(wp_n),
    .tap_sel0(tap_sel0), .tap_sel1(tap_sel1), .nv_busy(nv_busy));
  dps_host host_u (.sck(sck), .cs_n(cs_n), .hold_n(hold_n), .si(si), .so_o(so_o),
    .so_oe_n(so_oe_n));
  ////////////////////////////////////////
  function automatic logic [255:0] tap_of(input logic [7:0] pos);
    tap_of = '0;
    tap_of[pos] = 1'b1;
  endfunction
  function automatic logic [7:0] ins(input dps_pkg::dps_op_t op, input logic w,
                                     input int k, input int p);
    ins = {op, w, 1'b0, k[1:0], 1'b0, p[0]};
  endfunction
  task automatic check(input logic [255:0] seen, input logic [255:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic check_taps;
    check(tap_sel0, tap_of(exp_wiper[0]), "pot 0 taps");
    check(tap_sel1, tap_of(exp_wiper[1]), "pot 1 taps");
  endtask
  task automatic cmd(input logic [7:0] ib, input logic [7:0] db, input int n, input int pa);
    host_u.frame({id_b, ib, db}, n, pa, rd);
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic drain;
    for (int i = 0; i < 2 * NV_CYC && nv_busy !== 1'b0; i++) @(negedge clk_sys);
    check(nv_busy, 1'b0, "write time overrun");
  endtask
  task automatic finish_test;
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin : watchdog
    #1_000_000;
    num_errors++;
    $display("unexpected at %0t: timeout", $time);
    finish_test;
  end

  initial begin : main
    int p;
    int k;
    void'($urandom(32'h9E1E8B78));
    for (int i = 0; i < 8; i++) exp_store[i/4][i%4] = dps_pkg::DR_RESET;
    exp_wiper = '{dps_pkg::DR_RESET, dps_pkg::DR_RESET};
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    slave_addr_bit0 <= 1'($urandom);
    slave_addr_bit1 <= 1'($urandom);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    id_b = {dps_pkg::DEV_TYPE, 2'h0, slave_addr_bit1, slave_addr_bit0};
    check_taps;
    for (int i = 0; i < 6; i++) begin
      p = i % 2;
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      cmd(ins(dps_pkg::OP_WRITE, 1'b1, 0, p), v, 24, -1);
      exp_wiper[p] = v;
      check_taps;
      cmd(ins(dps_pkg::OP_READ, 1'b1, 0, p), 8'($urandom), 24, -1);
      check(rd, exp_wiper[p], "wiper read back");
    end
    for (int i = 0; i < 8; i++) begin
      p = i / 4;
      k = i % 4;
      v = 8'($urandom);
      cmd(ins(dps_pkg::OP_WRITE, 1'b0, k, p), v, 24, -1);
      check(nv_busy, 1'b1, "write time not running");
      drain;
      exp_store[p][k] = v;
      cmd(ins(dps_pkg::OP_READ, 1'b0, k, p), 8'h00, 24, 16 + i);
      check(rd, v, "stored read back");
    end
    for (p = 0; p < 2; p++) begin
      k = $urandom_range(3);
      cmd(ins(dps_pkg::OP_XFER, 1'b0, k, p), 8'h00, 16, -1);
      exp_wiper[p] = exp_store[p][k];
      check_taps;
      k = (k + 1) % 4;
      cmd(ins(dps_pkg::OP_STORE, 1'b0, k, p), 8'h00, 16, -1);
      exp_store[p][k] = exp_wiper[p];
      cmd(ins(dps_pkg::OP_WRITE, 1'b1, 0, p), ~exp_wiper[p], 24, -1);
      check_taps;
      drain;
      cmd(ins(dps_pkg::OP_READ, 1'b0, k, p), 8'h00, 24, -1);
      check(rd, exp_store[p][k], "stored wiper read back");
    end
    @(posedge clk_sys);
    wp_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cmd(ins(dps_pkg::OP_WRITE, 1'b0, 2, 1), ~exp_store[1][2], 24, -1);
    check(nv_busy, 1'b0, "protected write started");
    cmd(ins(dps_pkg::OP_STORE, 1'b0, 2, 1), 8'h00, 16, -1);
    check(nv_busy, 1'b0, "protected store started");
    v = 8'($urandom);
    cmd(ins(dps_pkg::OP_WRITE, 1'b1, 0, 1), v, 24, -1);
    exp_wiper[1] = v;
    check_taps;
    cmd(ins(dps_pkg::OP_READ, 1'b0, 2, 1), 8'h00, 24, -1);
    check(rd, exp_store[1][2], "protected register changed");
    @(posedge clk_sys);
    wp_n <= 1'b1;
    id_b[0] = ~id_b[0];
    cmd(ins(dps_pkg::OP_WRITE, 1'b1, 0, 0), ~exp_wiper[0], 24, -1);
    check_taps;
    finish_test;
  end
endmodule // dual_pot_serial_control_test
